// File: design/cmpi_defines.svh
// Register map, field positions, reset values and selector codes for the comparator control block
`ifndef CMPI_DEFINES_SVH
`define CMPI_DEFINES_SVH

// Byte addresses of the word registers
`define CMPI_OFF_CTRL1_0 5'h00
`define CMPI_OFF_CTRL1_1 5'h04
`define CMPI_OFF_MIRROR 5'h08
`define CMPI_OFF_CTRL0 5'h0C
`define CMPI_OFF_IRQ_STAT 5'h10
`define CMPI_OFF_IRQ_MASK 5'h14

// Field positions
`define CMPI_CTRL1_GAP_BIT 3
`define CMPI_CTRL0_EN_LSB 0
`define CMPI_CTRL0_INV_LSB 8

// Reset values and bus response codes
`define CMPI_CTRL1_RST 7'h00
`define CMPI_FLAG_RST 2'h0
`define CMPI_RESP_OKAY 2'h0
`define CMPI_RESP_SLVERR 2'h2

// Plus selector codes
`define CMPI_PSEL_AGND 2'h3
`define CMPI_PSEL_FIXREF 2'h2
`define CMPI_PSEL_DAC 2'h1
`define CMPI_PSEL_PIN 2'h0

// Minus selector codes
`define CMPI_NSEL_AGND 3'h7
`define CMPI_NSEL_FIXREF 3'h6
`define CMPI_NSEL_RSV_B 3'h5
`define CMPI_NSEL_RSV_A 3'h4
`define CMPI_NSEL_PIN3 3'h3
`define CMPI_NSEL_PIN2 3'h2

`endif

// File: design/cmpi_pkg.sv
// Types shared by the comparator control block
package cmpi_pkg;

	// Input and interrupt control fields of one comparator
	typedef struct packed {
		logic rise_edge_irq_en;
		logic fall_edge_irq_en;
		logic [1:0] plus_input_select;
		logic [2:0] minus_input_select;
	} cmpi_ctrl1_t;

	// One-hot analog routing for one comparator
	typedef struct packed {
		logic [3:0] plus_route;
		logic [5:0] minus_route;
	} cmpi_route_t;

endpackage

// File: design/cmpi_ctrl.sv
// Comparator input selection, edge interrupt logic and register slave
//
// How it works
// - Rising edge enable sets flag on rise
// - Falling edge enable sets flag on fall
// - Two-bit plus selector routes ground/ref/dac/pin
// - Three-bit minus selector routes, two codes reserved
// - Control bit three always reads zero
// - Mirror register shows outputs, upper bits zero
// - Every field and mirror clear on reset
// - Output is plus above minus, invertible
// - Software clears flag; concurrent edge keeps it
// - Polarity or enable toggle may raise flag
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cmpi_defines.svh"

module cmpi_ctrl
	import cmpi_pkg::*;
#(
	parameter int NUM_CMP = 2
)
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic [1:0] avs_response_o,
	output logic avs_waitrequest_o,
	// Analog side
	input wire logic [NUM_CMP-1:0] analog_gt_i,
	output cmpi_route_t [NUM_CMP-1:0] route_o,
	output logic [NUM_CMP-1:0] compare_enable_o,
	// Interrupt
	output logic irq_o
);

	// Register state
	cmpi_ctrl1_t ctrl_reg [NUM_CMP];
	cmpi_ctrl1_t ctrl_next [NUM_CMP];
	logic [NUM_CMP-1:0] enable_reg;
	logic [NUM_CMP-1:0] enable_next;
	logic [NUM_CMP-1:0] invert_reg;
	logic [NUM_CMP-1:0] invert_next;
	logic [NUM_CMP-1:0] result_reg;
	logic [NUM_CMP-1:0] result_next;
	logic [NUM_CMP-1:0] flag_reg;
	logic [NUM_CMP-1:0] flag_next;
	logic [NUM_CMP-1:0] mask_reg;
	logic [NUM_CMP-1:0] mask_next;
	logic [NUM_CMP-1:0] set_vec;
	logic [NUM_CMP-1:0] rise_evt;
	logic [NUM_CMP-1:0] fall_evt;
	logic [NUM_CMP-1:0] clr_vec;
	cmpi_route_t [NUM_CMP-1:0] route_reg;
	cmpi_route_t [NUM_CMP-1:0] route_next;
	logic wait_reg;
	logic wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0] resp_reg;
	logic [1:0] resp_next;
	logic irq_reg;
	logic irq_next;

	// Bus decode; a request is accepted on the cycle waitrequest is low
	wire logic req = avs_read_i | avs_write_i;
	wire logic acc = req & ~wait_reg;
	wire logic wr_acc = avs_write_i & ~wait_reg;
	wire logic hit_ctrl0 = avs_address_i == `CMPI_OFF_CTRL0;
	wire logic hit_stat = avs_address_i == `CMPI_OFF_IRQ_STAT;
	wire logic hit_mask = avs_address_i == `CMPI_OFF_IRQ_MASK;
	wire logic hit_mirror = avs_address_i == `CMPI_OFF_MIRROR;
	wire logic hit_c1_0 = avs_address_i == `CMPI_OFF_CTRL1_0;
	wire logic hit_c1_1 = (avs_address_i == `CMPI_OFF_CTRL1_1) && (NUM_CMP > 1);
	wire logic hit_any = hit_ctrl0 | hit_stat | hit_mask | hit_mirror | hit_c1_0 | hit_c1_1;
	wire logic be0 = avs_byteenable_i[0];
	wire logic be1 = avs_byteenable_i[1];

	// One wait cycle per access, then a one-cycle answer
	assign wait_next = ~(req & wait_reg);
	assign resp_next = hit_any ? `CMPI_RESP_OKAY : `CMPI_RESP_SLVERR;

	// Enable, invert, mask and write-one-to-clear lanes
	assign enable_next = (wr_acc && hit_ctrl0 && be0) ?
		avs_writedata_i[`CMPI_CTRL0_EN_LSB +: NUM_CMP] : enable_reg;
	assign invert_next = (wr_acc && hit_ctrl0 && be1) ?
		avs_writedata_i[`CMPI_CTRL0_INV_LSB +: NUM_CMP] : invert_reg;
	assign mask_next = (wr_acc && hit_mask && be0) ? avs_writedata_i[NUM_CMP-1:0] : mask_reg;
	assign clr_vec = (wr_acc && hit_stat && be0) ? avs_writedata_i[NUM_CMP-1:0] : '0;

	// Gating by enable before the invert lets enable and polarity flips cause edges
	assign result_next = (enable_reg & analog_gt_i) ^ invert_reg;
	assign rise_evt = result_next & ~result_reg;
	assign fall_evt = ~result_next & result_reg;

	// Set wins over a simultaneous clear
	assign flag_next = (flag_reg & ~clr_vec) | set_vec;
	assign irq_next = |(flag_next & mask_next);

	// Per comparator: edge gating, control write and input routing
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CMP; gi++)
		begin : g_cmp
			wire logic hit_me = (gi == 0) ? hit_c1_0 : hit_c1_1;
			wire logic [2:0] nsel = ctrl_next[gi].minus_input_select;
			wire logic pins_hi = (NUM_CMP > 1);
			assign set_vec[gi] = (rise_evt[gi] & ctrl_reg[gi].rise_edge_irq_en)
				| (fall_evt[gi] & ctrl_reg[gi].fall_edge_irq_en);
			// Bit three is never stored, so it cannot read back
			assign ctrl_next[gi] = (wr_acc && hit_me && be0) ?
				cmpi_ctrl1_t'({avs_writedata_i[7:4], avs_writedata_i[2:0]}) : ctrl_reg[gi];
			// Route decode is registered so the analog switches see clean levels
			assign route_next[gi].plus_route[3] = ctrl_next[gi].plus_input_select == `CMPI_PSEL_AGND;
			assign route_next[gi].plus_route[2] = ctrl_next[gi].plus_input_select == `CMPI_PSEL_FIXREF;
			assign route_next[gi].plus_route[1] = ctrl_next[gi].plus_input_select == `CMPI_PSEL_DAC;
			assign route_next[gi].plus_route[0] = ctrl_next[gi].plus_input_select == `CMPI_PSEL_PIN;
			// Reserved minus codes connect nothing
			assign route_next[gi].minus_route[5] = nsel == `CMPI_NSEL_AGND;
			assign route_next[gi].minus_route[4] = nsel == `CMPI_NSEL_FIXREF;
			assign route_next[gi].minus_route[3] = pins_hi && (nsel == `CMPI_NSEL_PIN3);
			assign route_next[gi].minus_route[2] = pins_hi && (nsel == `CMPI_NSEL_PIN2);
			assign route_next[gi].minus_route[1:0] = nsel[2] ? 2'h0 : (2'h1 << nsel[0]) & {2{~nsel[1]}};
		end
	endgenerate

	// Read data mux; mirror upper bits stay zero
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		if (hit_c1_0)
			rdata_next[7:0] = {ctrl_reg[0][6:3], 1'b0, ctrl_reg[0][2:0]};
		if (hit_c1_1)
			rdata_next[7:0] = {ctrl_reg[NUM_CMP-1][6:3], 1'b0, ctrl_reg[NUM_CMP-1][2:0]};
		if (hit_mirror)
			rdata_next[NUM_CMP-1:0] = result_reg;
		if (hit_ctrl0)
		begin
			rdata_next[`CMPI_CTRL0_EN_LSB +: NUM_CMP] = enable_reg;
			rdata_next[`CMPI_CTRL0_INV_LSB +: NUM_CMP] = invert_reg;
		end
		if (hit_stat)
			rdata_next[NUM_CMP-1:0] = flag_reg;
		if (hit_mask)
			rdata_next[NUM_CMP-1:0] = mask_reg;
	end

	// Bus handshake registers
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			resp_reg <= `CMPI_RESP_OKAY;
		end
		else
		begin
			wait_reg <= wait_next;
			rdata_reg <= (req & wait_reg) ? rdata_next : rdata_reg;
			resp_reg <= (req & wait_reg) ? resp_next : resp_reg;
		end
	end

	// Control and status registers, all clear on reset
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int k = 0; k < NUM_CMP; k++)
				ctrl_reg[k] <= `CMPI_CTRL1_RST;
			enable_reg <= '0;
			invert_reg <= '0;
			result_reg <= '0;
			flag_reg <= '0;
			mask_reg <= '0;
			route_reg <= '0;
			irq_reg <= 1'b0;
		end
		else
		begin
			for (int k = 0; k < NUM_CMP; k++)
				ctrl_reg[k] <= ctrl_next[k];
			enable_reg <= enable_next;
			invert_reg <= invert_next;
			result_reg <= result_next;
			flag_reg <= flag_next;
			mask_reg <= mask_next;
			route_reg <= route_next;
			irq_reg <= irq_next;
		end
	end

	// Outputs straight from flops
	assign avs_waitrequest_o = wait_reg;
	assign avs_readdata_o = rdata_reg;
	assign avs_response_o = resp_reg;
	assign route_o = route_reg;
	assign compare_enable_o = enable_reg;
	assign irq_o = irq_reg;

	// Checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);

	// Read answers seen on the bus
	wire logic rd_ack = avs_read_i & ~wait_reg;
	logic [4:0] ack_addr;
	assign ack_addr = avs_address_i;

	generate
		for (gi = 0; gi < NUM_CMP; gi++)
		begin : g_chk
			a_rise_sets_flag: assert property (rise_evt[gi] && ctrl_reg[gi].rise_edge_irq_en |=> flag_reg[gi])
				else $error("rising edge did not set flag");
			a_fall_sets_flag: assert property (fall_evt[gi] && ctrl_reg[gi].fall_edge_irq_en |=> flag_reg[gi])
				else $error("falling edge did not set flag");
			a_flag_has_cause: assert property ($rose(flag_reg[gi]) |-> $past(set_vec[gi]))
				else $error("flag rose without an enabled edge");
			// Route and selector load on one edge; the first edge out of reset still shows the reset route
			a_plus_route_hot: assert property ($past(rst_b_i)
				|-> route_o[gi].plus_route == (4'h1 << ctrl_reg[gi].plus_input_select))
				else $error("plus route does not match selector");
			a_minus_rsv_open: assert property (ctrl_reg[gi].minus_input_select[2:1] == 2'h2
				|-> route_o[gi].minus_route == 6'h00)
				else $error("reserved minus code routed something");
			a_result_polarity: assert property (##1 result_reg[gi]
				== ($past(enable_reg[gi] & analog_gt_i[gi]) ^ $past(invert_reg[gi])))
				else $error("result does not follow inputs and polarity");
			a_set_beats_clear: assert property (clr_vec[gi] && set_vec[gi] |=> flag_reg[gi])
				else $error("edge lost during clearing write");
			a_pol_toggle_irq: assert property (!enable_reg[gi] && $changed(invert_reg[gi])
				&& ctrl_reg[gi].rise_edge_irq_en && ctrl_reg[gi].fall_edge_irq_en |=> flag_reg[gi])
				else $error("polarity flip while disabled gave no flag");
		end
	endgenerate

	a_gap_bit_zero: assert property (rd_ack && (ack_addr == `CMPI_OFF_CTRL1_0)
		|-> avs_readdata_o[`CMPI_CTRL1_GAP_BIT] == 1'b0)
		else $error("unused control bit read as one");
	// Read data was captured one edge before the answer, so compare with the result of then
	a_mirror_read: assert property (rd_ack && (ack_addr == `CMPI_OFF_MIRROR)
		|-> avs_readdata_o == 32'($past(result_reg)))
		else $error("mirror read mismatch");
	a_reset_clear: assert property ($rose(rst_b_i) |-> result_reg == '0 && flag_reg == '0
		&& ctrl_reg[0] == `CMPI_CTRL1_RST)
		else $error("state not clear after reset");
	a_irq_level: assert property (##1 irq_o == $past(|(flag_next & mask_next)))
		else $error("interrupt output wrong");

	c_rise_irq: cover property (rise_evt[0] && ctrl_reg[0].rise_edge_irq_en ##1 irq_o);
	c_clear_race: cover property (clr_vec[0] && set_vec[0]);
	c_mirror_read: cover property (rd_ack && (ack_addr == `CMPI_OFF_MIRROR) && avs_readdata_o[0]);

endmodule

`default_nettype wire

// File: test/tb_comparator_input_irq_control.sv
// Self-checking bench for the comparator input routing and edge interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "cmpi_defines.svh"
module tb_comparator_input_irq_control;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [4:0] bus_addr = 5'h00;
	logic bus_rd = 1'b0;
	logic bus_wr = 1'b0;
	logic [31:0] bus_wdata = 32'h0;
	logic [31:0] bus_rdata;
	logic [1:0] bus_resp;
	logic bus_wait;
	logic [1:0] gt = 2'h0;
	cmpi_pkg::cmpi_route_t [1:0] route;
	logic [1:0] cmp_en;
	logic irq;
	logic [31:0] rd_q;
	logic [1:0] resp_q;
	logic [31:0] red_rdata;
	logic [1:0] red_resp;
	cmpi_pkg::cmpi_route_t [0:0] red_route;
	logic [31:0] rdr_q;
	logic [1:0] rdr_resp_q;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	int p;

	cmpi_ctrl #(.NUM_CMP(2)) cmpi_ctrl_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(bus_addr),
		.avs_read_i(bus_rd), .avs_write_i(bus_wr), .avs_writedata_i(bus_wdata), .avs_byteenable_i(4'hF),
		.avs_readdata_o(bus_rdata), .avs_response_o(bus_resp), .avs_waitrequest_o(bus_wait),
		.analog_gt_i(gt), .route_o(route), .compare_enable_o(cmp_en), .irq_o(irq));

	// Reduced variant on the same bus; its handshake timing equals the full one
	cmpi_ctrl #(.NUM_CMP(1)) cmpi_ctrl_r_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(bus_addr),
		.avs_read_i(bus_rd), .avs_write_i(bus_wr), .avs_writedata_i(bus_wdata), .avs_byteenable_i(4'hF),
		.avs_readdata_o(red_rdata), .avs_response_o(red_resp), .avs_waitrequest_o(),
		.analog_gt_i(gt[0:0]), .route_o(red_route), .compare_enable_o(), .irq_o());

	// Free-running system clock
	always #12.5 clk_sys_i = ~clk_sys_i;

	// Hang guard, far above the length of the sequence
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("comparisons %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// One access; chg moves the comparator inputs at the edge the request is first sampled, one edge before it is accepted,
	// so an edge lands on the same edge a write takes effect
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic chg,
		input logic [1:0] g);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		bus_rd <= ~w;
		bus_wr <= w;
		bus_addr <= a;
		bus_wdata <= d;
		forever
		begin
			@(posedge clk_sys_i);
			if (chg && n == 0)
				gt <= g;
			n++;
			if (bus_wait === 1'b0)
				break;
		end
		rd_q = bus_rdata;
		resp_q = bus_resp;
		rdr_q = red_rdata;
		rdr_resp_q = red_resp;
		bus_rd <= 1'b0;
		bus_wr <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 1'b0, 2'h0);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 1'b0, 2'h0);
		chk($sformatf("read at %h", a), e, rd_q);
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys_i);
	endtask

	// Main sequence
	initial
	begin
		tick(10);
		rst_b_i <= 1'b1;
		tick(3);
		rdc(`CMPI_OFF_CTRL1_0, 32'h0);
		rdc(`CMPI_OFF_CTRL1_1, 32'h0);
		rdc(`CMPI_OFF_MIRROR, 32'h0);
		rdc(`CMPI_OFF_IRQ_STAT, 32'h0);
		chk("route zero", 32'h41, {22'h0, route[0]});
		$display("reset test done");
		wr(`CMPI_OFF_CTRL1_0, 32'hFF);
		rdc(`CMPI_OFF_CTRL1_0, 32'hF7);
		wr(`CMPI_OFF_CTRL1_1, 32'h08);
		rdc(`CMPI_OFF_CTRL1_1, 32'h0);
		for (p = 0; p < 4; p++)
		begin
			wr(`CMPI_OFF_CTRL1_0, 32'(p << 4));
			tick(2);
			chk("plus route", 32'h1 << p, {28'h0, route[0].plus_route});
		end
		for (p = 0; p < 8; p++)
		begin
			wr(`CMPI_OFF_CTRL1_1, 32'(p));
			tick(2);
			chk("minus route", (p == 7) ? 32'h20 : (p == 6) ? 32'h10 : (p > 3) ? 32'h0 : 32'h1 << p,
				{26'h0, route[1].minus_route});
		end
		wr(`CMPI_OFF_CTRL1_0, 32'h3);
		tick(2);
		chk("minus route pin3", 32'h08, {26'h0, route[0].minus_route});
		chk("reduced minus route", 32'h0, {26'h0, red_route[0].minus_route});
		$display("selector test done");
		wr(`CMPI_OFF_CTRL0, 32'h1);
		wr(`CMPI_OFF_IRQ_MASK, 32'h3);
		wr(`CMPI_OFF_CTRL1_0, 32'h80);
		wr(`CMPI_OFF_IRQ_STAT, 32'h3);
		gt <= 2'h1;
		tick(3);
		rdc(`CMPI_OFF_MIRROR, 32'h1);
		rdc(`CMPI_OFF_IRQ_STAT, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`CMPI_OFF_IRQ_STAT, 32'h1);
		tick(2);
		chk("irq", 32'h0, {31'h0, irq});
		gt <= 2'h0;
		tick(3);
		rdc(`CMPI_OFF_IRQ_STAT, 32'h0);
		wr(`CMPI_OFF_CTRL1_0, 32'h40);
		gt <= 2'h1;
		tick(3);
		rdc(`CMPI_OFF_IRQ_STAT, 32'h0);
		gt <= 2'h0;
		tick(3);
		rdc(`CMPI_OFF_IRQ_STAT, 32'h1);
		wr(`CMPI_OFF_CTRL1_0, 32'hC0);
		bus(1'b1, `CMPI_OFF_IRQ_STAT, 32'h1, 1'b1, 2'h1);
		tick(2);
		rdc(`CMPI_OFF_IRQ_STAT, 32'h1);
		wr(`CMPI_OFF_IRQ_STAT, 32'h1);
		rdc(`CMPI_OFF_IRQ_STAT, 32'h0);
		$display("edge test done");
		wr(`CMPI_OFF_IRQ_MASK, 32'h0);
		gt <= 2'h0;
		tick(3);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`CMPI_OFF_IRQ_MASK, 32'h1);
		tick(2);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(`CMPI_OFF_IRQ_STAT, 32'h1);
		wr(`CMPI_OFF_CTRL1_1, 32'hC0);
		wr(`CMPI_OFF_CTRL0, 32'h201);
		tick(3);
		rdc(`CMPI_OFF_IRQ_STAT, 32'h2);
		chk("enable out", 32'h1, {30'h0, cmp_en});
		wr(`CMPI_OFF_MIRROR, 32'hFF);
		rdc(`CMPI_OFF_MIRROR, 32'h2);
		chk("mirror response", {30'h0, `CMPI_RESP_OKAY}, {30'h0, resp_q});
		chk("reduced mirror", 32'h0, rdr_q);
		rdc(`CMPI_OFF_CTRL1_1, 32'hC0);
		chk("reduced ctrl1", 32'h0, rdr_q);
		chk("reduced response", {30'h0, `CMPI_RESP_SLVERR}, {30'h0, rdr_resp_q});
		rdc(5'h18, 32'h0);
		chk("unmapped response", {30'h0, `CMPI_RESP_SLVERR}, {30'h0, resp_q});
		$display("polarity and map test done");
		wrap_up();
	end
endmodule
`default_nettype wire
